// *** design/pmb_bus_timing.sv ***
// Management-bus slave timing supervisor: timeouts, stretch budget, address latch, alert.
`timescale 1ns/100ps

module pmb_bus_timing #(
    parameter logic [pmb_pkg::CW-1:0] LOW_TO_CYC = pmb_pkg::LOW_TO_CYC,
    parameter logic [pmb_pkg::CW-1:0] IDLE_CYC = pmb_pkg::IDLE_CYC,
    parameter logic [pmb_pkg::CW-1:0] HIGH_CYC = pmb_pkg::HIGH_CYC,
    parameter logic [pmb_pkg::CW-1:0] SEXT_CYC = pmb_pkg::SEXT_CYC
) (
    // Clock and resets.
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ext_rst_i,
    // Bus pins, open drain.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Alert pin, open drain.
    output logic alert_o,
    output logic alert_oe_o,
    // Address-select band codes from the converter.
    input wire logic [3:0] addr_sel_coarse_i,
    input wire logic [3:0] addr_sel_fine_i,
    // Configuration.
    input wire logic timeout_disable_bit_i,
    // Slave core side.
    input wire logic sda_pull_i,
    input wire logic stretch_req_i,
    input wire logic alert_req_i,
    output pmb_pkg::pmb_ev_t ev_o,
    output pmb_pkg::pmb_addr_t addr_o,
    output logic active_o,
    output logic stretch_spent_o
);
    import pmb_pkg::*;

    // Saturating increment so a long stall never wraps a counter.
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v, input logic [CW-1:0] lim);
        sat_inc = (v >= lim) ? v : v + 1'b1;
    endfunction : sat_inc

    logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
    logic rst_s1_r, rst_s2_r, rst_d_r, rst;
    logic start_c, stop_c, low_hit, high_hit, idle_hit, abort_c, release_c;
    logic [CW-1:0] low_cnt_r, low_cnt_nxt, high_cnt_r, high_cnt_nxt;
    logic [CW-1:0] idle_cnt_r, idle_cnt_nxt, str_cnt_r, str_cnt_nxt;
    pmb_state_t st_r, st_nxt;
    pmb_ev_t ev_r, ev_nxt;
    pmb_addr_t addr_r, addr_nxt;
    logic [7:0] addr_calc;
    logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt, alert_oe_r, alert_oe_nxt;

    // Pins are asynchronous; each passes two flops before any logic reads it.
    always_ff @(posedge clock_i) begin
        scl_s1_r <= scl_i;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= sda_i;
        sda_s2_r <= sda_s1_r;
        rst_s1_r <= ext_rst_i;
        rst_s2_r <= rst_s1_r;
    end

    // The external pin resets everything the core reset does, except the clear of the address latch.
    assign rst = srst_i | rst_s2_r;
    assign release_c = rst_d_r & ~rst;

    // Start and stop are data edges while the clock is high.
    always_comb begin
        start_c = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
        stop_c = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    end

    // Low, high and idle duration counters plus the per-message stretch budget.
    always_comb begin
        low_cnt_nxt = scl_s2_r ? '0 : sat_inc(low_cnt_r, LOW_TO_CYC);
        high_cnt_nxt = (scl_s2_r && !start_c && !stop_c) ? sat_inc(high_cnt_r, HIGH_CYC) : '0;
        idle_cnt_nxt = (scl_s2_r && sda_s2_r) ? sat_inc(idle_cnt_r, IDLE_CYC) : '0;
        // Budget runs from the first start to stop; repeated starts keep it.
        if (st_r != PMB_ST_ACTIVE) begin
            str_cnt_nxt = '0;
        end else if (scl_oe_r) begin
            str_cnt_nxt = sat_inc(str_cnt_r, SEXT_CYC);
        end else begin
            str_cnt_nxt = str_cnt_r;
        end
    end

    // Abort causes; the high-side checks are masked by the disable bit.
    always_comb begin
        low_hit = ~scl_s2_r & (low_cnt_r == LOW_TO_CYC);
        high_hit = ~timeout_disable_bit_i & (high_cnt_r == HIGH_CYC);
        idle_hit = ~timeout_disable_bit_i & sda_s2_r & (idle_cnt_r == IDLE_CYC);
        abort_c = (st_r == PMB_ST_ACTIVE) & (low_hit | high_hit | idle_hit);
    end

    // Transaction state; an abort parks the block until a fresh start.
    always_comb begin
        st_nxt = st_r;
        ev_nxt = '0;
        ev_nxt.start = start_c;
        ev_nxt.stop = stop_c;
        unique case (st_r)
            PMB_ST_IDLE: begin
                if (start_c) begin
                    st_nxt = PMB_ST_ACTIVE;
                end
            end
            PMB_ST_ACTIVE: begin
                if (abort_c) begin
                    st_nxt = PMB_ST_IGNORE;
                    ev_nxt.abort = 1'b1;
                end else if (stop_c) begin
                    st_nxt = PMB_ST_IDLE;
                end
            end
            PMB_ST_IGNORE: begin
                if (start_c) begin
                    st_nxt = PMB_ST_ACTIVE;
                end
            end
            default: begin
                st_nxt = PMB_ST_IDLE;
            end
        endcase
    end

    // Line drives. Only a slave: the block never forces a start or a clock edge.
    // Stretching holds a low the master made and stops once the budget is spent.
    always_comb begin
        scl_oe_nxt = (st_nxt == PMB_ST_ACTIVE) && stretch_req_i && (scl_oe_r || !scl_s2_r)
            && (str_cnt_nxt < SEXT_CYC);
        sda_oe_nxt = (st_nxt == PMB_ST_ACTIVE) && sda_pull_i;
        alert_oe_nxt = alert_req_i;
    end

    // Address from the two band codes; bands 12 and up are out of range.
    always_comb begin
        addr_calc = 8'(addr_sel_coarse_i) * ADDR_COARSE_MUL + 8'(addr_sel_fine_i);
        addr_nxt = addr_r;
        if (release_c) begin
            addr_nxt.addr = addr_calc[6:0];
            addr_nxt.valid = (addr_sel_coarse_i < ADDR_BAND_LIMIT)
                && (addr_sel_fine_i < ADDR_BAND_LIMIT) && (addr_calc <= ADDR_MAX);
        end
    end

    // Registers for the transaction and line logic.
    always_ff @(posedge clock_i) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            low_cnt_r <= '0;
            high_cnt_r <= '0;
            idle_cnt_r <= '0;
            str_cnt_r <= '0;
            st_r <= PMB_ST_IDLE;
            ev_r <= '0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            alert_oe_r <= 1'b0;
        end else begin
            scl_d_r <= scl_s2_r;
            sda_d_r <= sda_s2_r;
            low_cnt_r <= low_cnt_nxt;
            high_cnt_r <= high_cnt_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            str_cnt_r <= str_cnt_nxt;
            st_r <= st_nxt;
            ev_r <= ev_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            alert_oe_r <= alert_oe_nxt;
        end
    end

    // Address latch lives outside reset so it can catch the release cycle.
    always_ff @(posedge clock_i) begin
        if (srst_i && !rst_d_r) begin
            addr_r <= '{valid: 1'b0, addr: ADDR_RST};
        end else begin
            addr_r <= addr_nxt;
        end
        rst_d_r <= rst;
    end

    // Outputs; the pin levels are always low, the enables do the work.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign alert_o = 1'b0;
    assign scl_oe_o = scl_oe_r;
    assign sda_oe_o = sda_oe_r;
    assign alert_oe_o = alert_oe_r;
    assign ev_o = ev_r;
    assign addr_o = addr_r;
    assign active_o = (st_r == PMB_ST_ACTIVE);
    assign stretch_spent_o = (str_cnt_r >= SEXT_CYC);

    // Checks on the timing behaviour.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst);

    low_abort_a: assert property ((st_r == PMB_ST_ACTIVE) && !scl_s2_r && (low_cnt_r == LOW_TO_CYC)
        |=> ev_r.abort && (st_r == PMB_ST_IGNORE)) else $error("low timeout not taken");
    idle_abort_a: assert property ((st_r == PMB_ST_ACTIVE) && scl_s2_r && sda_s2_r
        && !timeout_disable_bit_i && (idle_cnt_r == IDLE_CYC)
        |=> ev_r.abort) else $error("idle reset not taken");
    disable_gate_a: assert property (timeout_disable_bit_i && scl_s2_r && (st_r == PMB_ST_ACTIVE)
        |=> !ev_r.abort) else $error("abort while checks disabled");
    stretch_cap_a: assert property (scl_oe_o |-> (str_cnt_r < SEXT_CYC))
        else $error("stretch budget exceeded");
    high_abort_a: assert property ((st_r == PMB_ST_ACTIVE) && !timeout_disable_bit_i
        && (high_cnt_r == HIGH_CYC) |=> ev_r.abort) else $error("clock high not idle");
    addr_latch_a: assert property (release_c |=> (addr_r.addr == $past(addr_calc[6:0])))
        else $error("address not latched at release");
    addr_hold_a: assert property (!release_c |=> $stable(addr_r))
        else $error("address changed after release");
    addr_invalid_a: assert property (release_c && (addr_sel_coarse_i >= ADDR_BAND_LIMIT)
        |=> !addr_r.valid) else $error("out of range address accepted");
    ignore_quiet_a: assert property ((st_r == PMB_ST_IGNORE) |-> !sda_oe_o && !scl_oe_o)
        else $error("lines driven after abort");
    alert_follow_a: assert property (alert_req_i |=> alert_oe_o)
        else $error("alert not driven");

    msg_done_c: cover property ((st_r == PMB_ST_ACTIVE) ##1 ev_r.stop);
    abort_seen_c: cover property (ev_r.abort ##[1:1000] ev_r.start);
    stretch_seen_c: cover property (scl_oe_o [*8]);

endmodule : pmb_bus_timing

// *** include/pmb_pkg.sv ***
// Shared constants and types for the management-bus timing supervisor.
package pmb_pkg;

    // Counter width; holds the longest count of 10,000,000 cycles.
    localparam int CW = 24;

    // Core clock rate in kHz (200 MHz).
    localparam int unsigned CLK_KHZ = 200000;

    // Bus timing figures in their own units.
    localparam int unsigned T_TIMEOUT_MS = 25;
    localparam int unsigned T_IDLE_MS = 50;
    localparam int unsigned T_HIGH_US = 50;
    localparam int unsigned T_SEXT_MS = 25;

    // Cycle counts derived from the figures above.
    localparam logic [CW-1:0] LOW_TO_CYC = CW'(T_TIMEOUT_MS * CLK_KHZ);
    localparam logic [CW-1:0] IDLE_CYC = CW'(T_IDLE_MS * CLK_KHZ);
    localparam logic [CW-1:0] HIGH_CYC = CW'((T_HIGH_US * CLK_KHZ) / 1000);
    localparam logic [CW-1:0] SEXT_CYC = CW'(T_SEXT_MS * CLK_KHZ);

    // Address arithmetic: coarse step weight, band count, highest address and reset address.
    localparam logic [7:0] ADDR_COARSE_MUL = 8'h0c;
    localparam logic [3:0] ADDR_BAND_LIMIT = 4'hc;
    localparam logic [7:0] ADDR_MAX = 8'h7f;
    localparam logic [6:0] ADDR_RST = 7'h00;

    // Transaction tracking states.
    typedef enum logic [1:0] {
        PMB_ST_IDLE = 2'b00,
        PMB_ST_ACTIVE = 2'b01,
        PMB_ST_IGNORE = 2'b10
    } pmb_state_t;

    // Bus events reported to the slave core.
    typedef struct packed {
        logic start;
        logic stop;
        logic abort;
    } pmb_ev_t;

    // Latched slave address.
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } pmb_addr_t;

endpackage : pmb_pkg

// *** verification/pmb_host_model.sv ***
// Bus master model driving the open-drain clock and data lines.
`timescale 1ns/100ps
module pmb_host_model (
    // Clock and device pulls.
    input wire logic clock_i,
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    // Resolved wire levels.
    output logic scl_o,
    output logic sda_o
);
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    // Set when a slave stretch outlasts the wait below; the bench judges it.
    logic stalled = 1'b0;
    // Pull-ups make a released line read high; either party may pull low.
    assign scl_o = m_scl & ~scl_oe_i;
    assign sda_o = m_sda & ~sda_oe_i;
    // Waits whole core cycles on the falling edge, where the bench drives.
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    // Data falls while the clock is high, then the clock goes low.
    task automatic start();
        m_sda = 1'b0;
        cyc(16);
        m_scl = 1'b0;
        cyc(16);
    endtask : start
    // Data rises while the clock is high.
    task automatic stop();
        m_sda = 1'b0;
        cyc(16);
        m_scl = 1'b1;
        cyc(16);
        m_sda = 1'b1;
        cyc(16);
    endtask : stop
    // One 50% duty bit; the high phase waits out a slave stretch.
    task automatic bit_out(input logic b);
        m_sda = b;
        cyc(16);
        m_scl = 1'b1;
        for (int k = 0; k < 400 && !scl_o; k++) cyc(1);
        if (!scl_o) stalled = 1'b1;
        cyc(16);
        m_scl = 1'b0;
    endtask : bit_out
endmodule : pmb_host_model

// *** verification/pmb_bus_timing_tb_top.sv ***
// Self-checking bench for the bus timing supervisor.
`timescale 1ns/100ps
module pmb_bus_timing_tb_top;
    import pmb_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic ext_rst_i = 1'b0;
    logic [3:0] coarse = 4'h2;
    logic [3:0] fine = 4'h5;
    logic tdis = 1'b0;
    logic sda_pull = 1'b0;
    logic stretch_req = 1'b0;
    logic alert_req = 1'b0;
    logic scl_w, sda_w, scl_oe, sda_oe, alert_oe, active, spent;
    logic scl_lvl, sda_lvl, alert_lvl;
    logic [3:0] s;
    pmb_ev_t ev;
    pmb_addr_t addr;
    int n_mismatch = 0;
    int num_checks = 0;
    // Core clock, 5 ns period.
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    pmb_host_model host (.clock_i(clock_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
        .scl_o(scl_w), .sda_o(sda_w));
    // Short counts keep the run brief; every expectation below follows them.
    pmb_bus_timing #(.LOW_TO_CYC(24'd200), .IDLE_CYC(24'd400), .HIGH_CYC(24'd60),
        .SEXT_CYC(24'd150)) dut (.clock_i(clock_i), .srst_i(srst_i), .ext_rst_i(ext_rst_i),
        .scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_lvl),
        .sda_oe_o(sda_oe), .alert_o(alert_lvl), .alert_oe_o(alert_oe),
        .addr_sel_coarse_i(coarse),
        .addr_sel_fine_i(fine), .timeout_disable_bit_i(tdis), .sda_pull_i(sda_pull),
        .stretch_req_i(stretch_req), .alert_req_i(alert_req), .ev_o(ev), .addr_o(addr),
        .active_o(active), .stretch_spent_o(spent));
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Collects event and budget flags until a masked one shows or n cycles pass.
    task automatic watch(input int n, input logic [3:0] mask, input logic must);
        s = 4'h0;
        for (int k = 0; k < n && (s & mask) == 4'h0; k++) begin
            cyc(1);
            s = s | {spent, ev.abort, ev.stop, ev.start};
        end
        if (must && (s & mask) == 4'h0) begin
            chk("event wait", {4'h0, mask}, 8'h00);
            wrap_up();
        end
    endtask : watch
    // Reset mid-transaction, then the latch sees in-range, top, coarse-band and over-limit addresses once each.
    task automatic t_addr();
        logic [7:0] pins [4] = '{8'h25, 8'ha7, 8'hc0, 8'ha8};
        logic [7:0] want [4] = '{8'h9d, 8'hff, 8'h00, 8'h00};
        host.start();
        for (int i = 0; i < 4; i++) begin
            {coarse, fine} = pins[i];
            ext_rst_i = 1'b1;
            cyc(5);
            chk("active in reset", 8'h00, {7'h0, active});
            ext_rst_i = 1'b0;
            cyc(6);
            {coarse, fine} = 8'h33;
            cyc(3);
            chk("addr valid", {7'h0, want[i][7]}, {7'h0, addr.valid});
            if (want[i][7]) chk("addr", want[i], addr);
        end
        host.stop();
        $display("test address done");
    endtask : t_addr
    // A clean message: start, a bit, a data pull, stop.
    task automatic t_txn();
        fork
            host.start();
            watch(40, 4'h1, 1'b1);
        join
        chk("active", 8'h01, {7'h0, active});
        host.bit_out(1'b1);
        chk("clock released", 8'h00, {7'h0, host.stalled});
        sda_pull = 1'b1;
        cyc(2);
        chk("sda pull", 8'h01, {7'h0, sda_oe});
        sda_pull = 1'b0;
        fork
            host.stop();
            watch(60, 4'h2, 1'b1);
        join
        chk("abort in message", 8'h00, {7'h0, s[2]});
        chk("active", 8'h00, {7'h0, active});
        $display("test transfer done");
    endtask : t_txn
    // Master parks the clock low beyond the timeout.
    task automatic t_low();
        fork
            host.start();
            watch(300, 4'h4, 1'b1);
        join
        chk("active", 8'h00, {7'h0, active});
        sda_pull = 1'b1;
        stretch_req = 1'b1;
        cyc(3);
        chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
        sda_pull = 1'b0;
        stretch_req = 1'b0;
        host.stop();
        $display("test low timeout done");
    endtask : t_low
    // Both lines held high mid-message; disabled, it outlasts the idle count too.
    task automatic t_high(input logic dis);
        tdis = dis;
        host.start();
        host.m_sda = 1'b1;
        cyc(2);
        host.m_scl = 1'b1;
        watch(dis ? 450 : 100, 4'h4, !dis);
        chk("high abort", {7'h0, !dis}, {7'h0, s[2]});
        chk("active", {7'h0, dis}, {7'h0, active});
        host.m_scl = 1'b0;
        cyc(16);
        host.stop();
        tdis = 1'b0;
        $display("test clock high done");
    endtask : t_high
    // Device stretches until its budget is used up.
    task automatic t_stretch();
        host.start();
        stretch_req = 1'b1;
        cyc(3);
        chk("stretch", 8'h01, {7'h0, scl_oe});
        watch(200, 4'h8, 1'b1);
        host.m_scl = 1'b1;
        cyc(2);
        chk("stretch spent", 8'h00, {7'h0, scl_oe});
        chk("pin levels", 8'h00, {5'h0, scl_lvl, sda_lvl, alert_lvl});
        stretch_req = 1'b0;
        cyc(14);
        host.stop();
        alert_req = 1'b1;
        cyc(2);
        chk("alert", 8'h01, {7'h0, alert_oe});
        alert_req = 1'b0;
        cyc(2);
        chk("alert", 8'h00, {7'h0, alert_oe});
        $display("test stretch and alert done");
    endtask : t_stretch
    // Main sequence.
    initial begin
        cyc(5);
        srst_i = 1'b0;
        cyc(4);
        chk("addr", 8'h9d, addr);
        t_addr();
        t_txn();
        t_low();
        t_high(1'b0);
        t_high(1'b1);
        t_stretch();
        wrap_up();
    end
    // Cuts a hang short.
    initial begin
        cyc(40000);
        n_mismatch++;
        wrap_up();
    end
endmodule : pmb_bus_timing_tb_top
